// ===== src/usc_pkg.sv
// Package: register map, field positions, constants and types of the serial transceiver
package usc_pkg;
  // Byte addresses on the register bus
  localparam logic [7:0] A_TXCS = 8'h00;
  localparam logic [7:0] A_RXCS = 8'h04;
  localparam logic [7:0] A_BAUD = 8'h08;
  localparam logic [7:0] A_TXD = 8'h0c;
  localparam logic [7:0] A_RXD = 8'h10;
  // transmit_control_status fields
  localparam int TX_CLOCK_SOURCE_MASTER = 7;
  localparam int TX_9 = 6;
  localparam int TX_EN = 5;
  localparam int TX_SYNC = 4;
  localparam int TX_BRK = 3;
  localparam int TX_HS = 2;
  localparam int TX_EMPTY = 1;
  localparam int TX_9D = 0;
  // receive_control_status fields
  localparam int RX_SERIAL_PORT_ON = 7;
  localparam int RX_9 = 6;
  localparam int RX_SINGLE_RECEIVE_ON = 5;
  localparam int RX_CONTINUOUS_RECEIVE_ON = 4;
  localparam int RX_ADDEN = 3;
  localparam int RX_FRAMING_ERROR_FLAG = 2;
  localparam int RX_OVERRUN_ERROR_FLAG = 1;
  localparam int RX_9D = 0;
  // Baud register: divisor low half, clock polarity above it
  localparam int BD_POL = 16;
  localparam logic [15:0] BRG_RST = 16'h0000;
  // Ticks per bit minus one, and half-bit sample point
  localparam logic [3:0] PH_LAST_HI = 4'h3;
  localparam logic [3:0] PH_LAST_LO = 4'hf;
  localparam logic [3:0] PH_HALF_HI = 4'h1;
  localparam logic [3:0] PH_HALF_LO = 4'h7;
  // Data bit counts minus one
  localparam logic [3:0] NB8_LAST = 4'h7;
  localparam logic [3:0] NB9_LAST = 4'h8;
  // Whole async frame lengths including start and stop
  localparam logic [3:0] LEN8 = 4'ha;
  localparam logic [3:0] LEN9 = 4'hb;
  localparam logic [3:0] LEN_BRK = 4'he;
  // Start, twelve zero bits, stop
  localparam logic [13:0] BRK_FRAME = 14'h2000;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  typedef struct packed {
    logic framing_error_flag;
    logic ninth;
    logic [7:0] data;
  } usc_rxw_s;

  typedef enum logic [1:0] {
    RX_IDLE = 2'h0,
    RX_START = 2'h1,
    RX_DATA = 2'h3,
    RX_STOP = 2'h2
  } usc_rx_e;
endpackage

// ===== src/usc_buf.sv
// Small receive buffer with valid/ready on both sides
module usc_buf #(
  parameter int W = 10,
  parameter int D = 2
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic clr,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam logic [AW:0] FULL = (AW + 1)'(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp, rp;
  logic [AW:0] cnt;
  logic push, pop;

  assign in_ready = cnt != FULL;
  assign out_valid = cnt != '0;
  assign out_data = mem[rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end else if (clr) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end else begin
      if (push) wp <= (wp == AW'(D - 1)) ? '0 : wp + 1'b1;
      if (pop) rp <= (rp == AW'(D - 1)) ? '0 : rp + 1'b1;
      cnt <= cnt + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end

  always_ff @(posedge clk) begin
    if (push) mem[wp] <= in_data;
  end
endmodule

// ===== src/usc_top.sv
// Serial transceiver: AXI4-Lite registers, async and sync engines, pin control
//
// The AXI4-Lite register port and the placing of the registers were chosen for this implementation.
module usc_top
  import usc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic tx_ck_i,
  output logic tx_ck_o,
  output logic tx_ck_oe,
  input wire logic rx_dt_i,
  output logic rx_dt_o,
  output logic rx_dt_oe
);
  logic clock_source_master, tx9, transmit_on, sync, break_send_request, hs, t9d;
  logic serial_port_on, rx9, single_receive_on, continuous_receive_on, adden, overrun_error_flag;
  logic [15:0] baud_generator;
  logic pol;
  logic hold_full;
  logic [7:0] hold_d;
  logic aw_got, w_got, next_aw_got, next_w_got, next_rvalid;
  logic [7:0] aw_a;
  logic [31:0] w_d;
  logic [3:0] w_s;
  logic [31:0] rd_val;
  logic rd_map;
  logic [7:0] wa, ra;
  logic aw_fire, w_fire, ar_fire, wr_fire, wr_map;
  logic wr_txcs, wr_rxcs, wr_baud, wr_txd, pop;
  logic [15:0] pre;
  logic tick;
  logic [3:0] ph_last, ph_half;
  logic [1:0] pin_m, pin_s, pin_p;
  logic dts;
  logic tx_busy, tx_brk, a_start, tx_end;
  logic [13:0] tx_sh;
  logic [3:0] tx_ph, tx_cnt, tx_len;
  usc_rx_e rx_st;
  logic [3:0] rx_ph, rx_cnt, rx_last;
  logic [8:0] rx_sh;
  logic rx_on, a_push;
  logic sy_act, sy_rx, ck_lvl, rxm, s_start, s_edge, lead, trail, sy_end, s_push;
  logic m_lead, m_trail;
  logic [8:0] sy_sh, src;
  logic [3:0] sy_cnt, sy_last;
  logic tx_take, tx_empty, push, in_ready, out_valid, ovr, single_receive_on_clr;
  usc_rxw_s in_w, hd, out_w;

  //////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave: write address and data taken in either order
  assign aw_fire = s_axi_awvalid && s_axi_awready;
  assign w_fire = s_axi_wvalid && s_axi_wready;
  assign ar_fire = s_axi_arvalid && s_axi_arready;
  assign wr_fire = aw_got && w_got && !s_axi_bvalid;
  assign next_aw_got = (aw_got || aw_fire) && !wr_fire;
  assign next_w_got = (w_got || w_fire) && !wr_fire;
  assign next_rvalid = ar_fire || (s_axi_rvalid && !s_axi_rready);
  assign wa = {aw_a[7:2], 2'h0};
  assign ra = {s_axi_araddr[7:2], 2'h0};
  assign wr_map = wa inside {A_TXCS, A_RXCS, A_BAUD, A_TXD, A_RXD};
  assign wr_txcs = wr_fire && wa == A_TXCS && w_s[0];
  assign wr_rxcs = wr_fire && wa == A_RXCS && w_s[0];
  assign wr_baud = wr_fire && wa == A_BAUD;
  assign wr_txd = wr_fire && wa == A_TXD && w_s[0];
  // Reading the data word pops the buffer head
  assign pop = ar_fire && ra == A_RXD;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_a <= '0;
      w_d <= '0;
      w_s <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OK;
    end else begin
      aw_got <= next_aw_got;
      w_got <= next_w_got;
      s_axi_awready <= !next_aw_got;
      s_axi_wready <= !next_w_got;
      if (aw_fire) aw_a <= s_axi_awaddr;
      if (w_fire) begin
        w_d <= s_axi_wdata;
        w_s <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_map ? RESP_OK : RESP_ERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // The framing flag and ninth bit come from the buffer head so they track the word being read
  assign hd = out_valid ? out_w : '0;

  always_comb begin
    rd_val = '0;
    rd_map = 1'b1;
    case (ra)
      A_TXCS: rd_val[7:0] = {clock_source_master, tx9, transmit_on, sync, break_send_request, hs, tx_empty, t9d};
      A_RXCS: rd_val[7:0] = {serial_port_on, rx9, single_receive_on, continuous_receive_on, adden, hd.framing_error_flag, overrun_error_flag, hd.ninth};
      A_BAUD: rd_val[BD_POL:0] = {pol, baud_generator};
      A_TXD: rd_val[8:0] = {hold_full, hold_d};
      A_RXD: rd_val[8:0] = {hd.ninth, hd.data};
      default: rd_map = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OK;
    end else begin
      s_axi_arready <= !next_rvalid;
      if (ar_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= rd_map ? RESP_OK : RESP_ERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Control registers
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      {clock_source_master, tx9, transmit_on, sync, hs, t9d} <= '0;
      break_send_request <= 1'b0;
    end else begin
      if (wr_txcs) begin
        clock_source_master <= w_d[TX_CLOCK_SOURCE_MASTER];
        tx9 <= w_d[TX_9];
        transmit_on <= w_d[TX_EN];
        sync <= w_d[TX_SYNC];
        hs <= w_d[TX_HS];
        t9d <= w_d[TX_9D];
      end
      // A write in the same cycle as completion keeps what software asked
      if (wr_txcs) break_send_request <= w_d[TX_BRK];
      else if (tx_end && tx_brk) break_send_request <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      {serial_port_on, rx9, continuous_receive_on, adden} <= '0;
      single_receive_on <= 1'b0;
      overrun_error_flag <= 1'b0;
      baud_generator <= BRG_RST;
      pol <= 1'b0;
    end else begin
      if (wr_rxcs) begin
        serial_port_on <= w_d[RX_SERIAL_PORT_ON];
        rx9 <= w_d[RX_9];
        continuous_receive_on <= w_d[RX_CONTINUOUS_RECEIVE_ON];
        adden <= w_d[RX_ADDEN];
      end
      if (wr_rxcs) single_receive_on <= w_d[RX_SINGLE_RECEIVE_ON];
      else if (single_receive_on_clr) single_receive_on <= 1'b0;
      // Set wins over the clearing write
      if (ovr) overrun_error_flag <= 1'b1;
      else if ((wr_rxcs && !w_d[RX_CONTINUOUS_RECEIVE_ON]) || !serial_port_on) overrun_error_flag <= 1'b0;
      if (wr_baud && w_s[0]) baud_generator[7:0] <= w_d[7:0];
      if (wr_baud && w_s[1]) baud_generator[15:8] <= w_d[15:8];
      if (wr_baud && w_s[2]) pol <= w_d[BD_POL];
    end
  end

  // Holding register; a write while full is dropped
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      hold_full <= 1'b0;
      hold_d <= '0;
    end else if (!serial_port_on) begin
      hold_full <= 1'b0;
    end else if (tx_take) begin
      hold_full <= 1'b0;
    end else if (wr_txd && !hold_full) begin
      hold_full <= 1'b1;
      hold_d <= w_d[7:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Baud divider and pin synchronisers
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pre <= '0;
      tick <= 1'b0;
    end else if (!serial_port_on || pre >= baud_generator) begin
      pre <= '0;
      tick <= serial_port_on;
    end else begin
      pre <= pre + 16'h1;
      tick <= 1'b0;
    end
  end

  assign ph_last = hs ? PH_LAST_HI : PH_LAST_LO;
  assign ph_half = hs ? PH_HALF_HI : PH_HALF_LO;

  // Bit 1 is the clock pin, bit 0 the data pin
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pin_m <= 2'h3;
      pin_s <= 2'h3;
      pin_p <= 2'h3;
    end else begin
      pin_m <= {tx_ck_i, rx_dt_i};
      pin_s <= pin_m;
      pin_p <= pin_s;
    end
  end
  assign dts = pin_s[0];

  //////////////////////////////////////////////////////////////////////////
  // Asynchronous transmitter
  assign a_start = serial_port_on && !sync && transmit_on && hold_full && !tx_busy;
  assign tx_end = tx_busy && tick && tx_ph == ph_last && tx_cnt == tx_len - 4'h1;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      tx_busy <= 1'b0;
      tx_brk <= 1'b0;
      tx_sh <= '1;
      tx_ph <= '0;
      tx_cnt <= '0;
      tx_len <= LEN8;
    end else if (!serial_port_on) begin
      tx_busy <= 1'b0;
      tx_sh <= '1;
    end else if (a_start) begin
      tx_busy <= 1'b1;
      tx_brk <= break_send_request;
      tx_ph <= '0;
      tx_cnt <= '0;
      if (break_send_request) begin
        tx_sh <= BRK_FRAME;
        tx_len <= LEN_BRK;
      end else if (tx9) begin
        tx_sh <= {4'hf, t9d, hold_d, 1'b0};
        tx_len <= LEN9;
      end else begin
        tx_sh <= {5'h1f, hold_d, 1'b0};
        tx_len <= LEN8;
      end
    end else if (tx_busy && tick) begin
      if (tx_ph == ph_last) begin
        tx_ph <= '0;
        tx_sh <= {1'b1, tx_sh[13:1]};
        tx_cnt <= tx_cnt + 4'h1;
        if (tx_end) tx_busy <= 1'b0;
      end else begin
        tx_ph <= tx_ph + 4'h1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Asynchronous receiver, runs alongside the transmitter
  assign rx_on = serial_port_on && !sync && continuous_receive_on && !overrun_error_flag;
  assign rx_last = rx9 ? NB9_LAST : NB8_LAST;
  assign a_push = rx_st == RX_STOP && tick && rx_ph == ph_last;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rx_st <= RX_IDLE;
      rx_ph <= '0;
      rx_cnt <= '0;
      rx_sh <= '0;
    end else if (!rx_on) begin
      rx_st <= RX_IDLE;
    end else begin
      case (rx_st)
        RX_IDLE: begin
          if (pin_p[0] && !dts) begin
            rx_st <= RX_START;
            rx_ph <= '0;
          end
        end
        RX_START: begin
          if (tick && rx_ph == ph_half) begin
            // A glitch shorter than half a bit is not a start
            rx_st <= dts ? RX_IDLE : RX_DATA;
            rx_ph <= '0;
            rx_cnt <= '0;
          end else if (tick) begin
            rx_ph <= rx_ph + 4'h1;
          end
        end
        RX_DATA: begin
          if (tick && rx_ph == ph_last) begin
            rx_ph <= '0;
            rx_sh <= {dts, rx_sh[8:1]};
            rx_cnt <= rx_cnt + 4'h1;
            if (rx_cnt == rx_last) rx_st <= RX_STOP;
          end else if (tick) begin
            rx_ph <= rx_ph + 4'h1;
          end
        end
        RX_STOP: begin
          if (a_push) rx_st <= RX_IDLE;
          else if (tick) rx_ph <= rx_ph + 4'h1;
        end
        default: rx_st <= RX_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Synchronous half-duplex engine, master or slave
  assign rxm = sync && (continuous_receive_on || (single_receive_on && clock_source_master));
  assign m_lead = clock_source_master && tick && sy_act && ck_lvl == pol;
  assign m_trail = clock_source_master && tick && sy_act && ck_lvl != pol;
  assign s_edge = pin_s[1] != pin_p[1];
  assign lead = clock_source_master ? m_lead : s_edge && pin_p[1] == pol;
  assign trail = clock_source_master ? m_trail : s_edge && pin_p[1] != pol;
  assign sy_last = (sy_rx ? rx9 : tx9) ? NB9_LAST : NB8_LAST;
  assign sy_end = sy_act && trail && sy_cnt == sy_last;
  assign s_start = serial_port_on && sync && !sy_act && (rxm ? !overrun_error_flag : transmit_on && hold_full);
  assign s_push = sy_end && sy_rx;
  assign single_receive_on_clr = s_push && clock_source_master && single_receive_on && !continuous_receive_on;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sy_act <= 1'b0;
      sy_rx <= 1'b0;
      ck_lvl <= 1'b0;
      sy_sh <= '0;
      sy_cnt <= '0;
    end else if (!serial_port_on || !sync) begin
      sy_act <= 1'b0;
      ck_lvl <= pol;
    end else if (s_start) begin
      sy_act <= 1'b1;
      sy_rx <= rxm;
      sy_cnt <= '0;
      sy_sh <= {t9d, hold_d};
    end else if (sy_act) begin
      if (m_lead || m_trail) ck_lvl <= !ck_lvl;
      // Data moves on the leading edge so it is stable at the trailing one
      if (lead && !sy_rx && sy_cnt != '0) sy_sh <= {1'b0, sy_sh[8:1]};
      if (trail) begin
        sy_cnt <= sy_cnt + 4'h1;
        if (sy_rx) sy_sh <= {dts, sy_sh[8:1]};
        if (sy_end) sy_act <= 1'b0;
      end
    end else begin
      ck_lvl <= pol;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Receive path into the buffer, overrun when it is full
  assign tx_take = a_start || (s_start && !rxm);
  assign tx_empty = !(tx_busy || (sy_act && !sy_rx));
  assign push = a_push || s_push;
  assign src = a_push ? rx_sh : {dts, sy_sh[8:1]};
  assign in_w.framing_error_flag = a_push && !dts;
  assign in_w.ninth = rx9 ? src[8] : 1'b0;
  assign in_w.data = rx9 ? src[7:0] : src[8:1];
  assign ovr = push && !in_ready;

  usc_buf #(.W($bits(usc_rxw_s)), .D(2)) u_buf (
    .clk(sys_clk),
    .resetn(resetn),
    .clr(!serial_port_on),
    .in_valid(push),
    .in_ready(in_ready),
    .in_data(in_w),
    .out_valid(out_valid),
    .out_ready(pop),
    .out_data(out_w)
  );

  //////////////////////////////////////////////////////////////////////////
  // Pin drivers
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      tx_ck_o <= 1'b1;
      tx_ck_oe <= 1'b0;
      rx_dt_o <= 1'b0;
      rx_dt_oe <= 1'b0;
    end else begin
      tx_ck_oe <= serial_port_on && (!sync || clock_source_master);
      tx_ck_o <= sync ? ck_lvl : (tx_busy ? tx_sh[0] : 1'b1);
      rx_dt_oe <= serial_port_on && sync && sy_act && !sy_rx;
      rx_dt_o <= sy_sh[0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks
  pins_off_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    !serial_port_on |=> !tx_ck_oe && !rx_dt_oe) else $error("pins driven while port off");
  held_rst_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    !serial_port_on |=> !tx_busy && !sy_act && rx_st == RX_IDLE) else $error("engine ran off");
  idle_high_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    serial_port_on && !sync && !tx_busy |=> tx_ck_o) else $error("async idle line low");
  brk_low_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    tx_busy && tx_brk && tx_cnt < LEN_BRK - 4'h1 |-> !tx_sh[0]) else $error("break high");
  brk_clr_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    tx_end && tx_brk && !wr_txcs |=> !break_send_request) else $error("break bit kept");
  frame_len_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    a_start && !break_send_request |=> tx_len == ($past(tx9) ? LEN9 : LEN8)
      && tx_sh[9] == ($past(tx9) ? $past(t9d) : 1'b1))
    else $error("wrong frame");
  ninth_out_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    a_start && tx9 && !break_send_request |=> tx_sh[9] == $past(t9d)) else $error("ninth bit lost");
  tx_override_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    serial_port_on && sync && rxm && !sy_act |=> !(sy_act && !sy_rx)) else $error("tx beat rx");
  empty_flag_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    a_start |=> !tx_empty ##1 !tx_empty) else $error("empty while sending");
  single_receive_on_clr_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    single_receive_on_clr && !wr_rxcs |=> !single_receive_on) else $error("single receive stuck");
  overrun_error_flag_set_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    ovr |=> overrun_error_flag) else $error("overrun missed");
  overrun_error_flag_keep_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    $fell(overrun_error_flag) |-> $past(wr_rxcs && !w_d[RX_CONTINUOUS_RECEIVE_ON]) || $past(!serial_port_on))
    else $error("overrun cleared");
  ck_idle_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    serial_port_on && sync && clock_source_master && !sy_act && !s_start |=> ##1 tx_ck_o == pol)
    else $error("clock not idle");
  async_tx_c: cover property (@(posedge sys_clk) disable iff (!resetn) tx_end && !tx_brk);
  break_c: cover property (@(posedge sys_clk) disable iff (!resetn) tx_end && tx_brk);
  sync_rx_c: cover property (@(posedge sys_clk) disable iff (!resetn) s_push && clock_source_master);
  overrun_c: cover property (@(posedge sys_clk) disable iff (!resetn) ovr);
endmodule

// ===== tb/usc_peer.sv
// Far-side serial peer: async sender and catcher, sync slave clock source
module usc_peer (
  input wire logic sys_clk,
  input wire logic line_in,
  output logic line_out,
  output logic clk_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    line_out = 1'b1;
    clk_out = 1'b0;
  end
  ////////////////////////////////////////
  // Start low, data LSB first, chosen stop level, then idle high
  task automatic send(input logic [8:0] v, input int n, input int bc, input logic stp);
    for (int i = 0; i <= n + 1; i++) begin
      @(posedge sys_clk);
      line_out <= (i == 0) ? 1'b0 : (i > n) ? stp : v[i-1];
      repeat (bc - 1) @(posedge sys_clk);
    end
    @(posedge sys_clk);
    line_out <= 1'b1;
  endtask
  // Bounded wait for a start bit, then sample mid-bit; bit n is the stop
  task automatic catch(input int n, input int bc, output logic [12:0] v);
    int k;
    v = '1;
    for (k = 0; k < 4000 && line_in !== 1'b0; k++) @(posedge sys_clk);
    if (k == 4000) tb_top.hang();
    repeat (bc / 2) @(posedge sys_clk);
    for (int i = 0; i <= n; i++) begin
      repeat (bc) @(posedge sys_clk);
      v[i] = line_in;
    end
  endtask
  // Data set with the leading edge; clock stands still between characters
  task automatic ssend(input logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      @(posedge sys_clk);
      line_out <= v[i];
      clk_out <= 1'b1;
      repeat (4) @(posedge sys_clk);
      clk_out <= 1'b0;
      repeat (3) @(posedge sys_clk);
    end
    @(posedge sys_clk);
    line_out <= ~v[7];
  endtask
endmodule

// ===== tb/tb_top.sv
// Bench for the serial transceiver: register bus master, serial peer, random traffic
module tb_top
  import usc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic tx_ck_o, tx_ck_oe, rx_dt_o, rx_dt_oe, peer_dt, peer_ck;
  // Pin levels: whoever enables drives, else the peer
  wire logic tx_ck_i = tx_ck_oe ? tx_ck_o : peer_ck;
  wire logic rx_dt_i = rx_dt_oe ? rx_dt_o : peer_dt;
  int fails = 0, cmp_count = 0;
  always #10 sys_clk = ~sys_clk;
  usc_top dut (.*);
  usc_peer peer (.sys_clk(sys_clk), .line_in(tx_ck_i), .line_out(peer_dt), .clk_out(peer_ck));
  ////////////////////////////////////////
  task automatic conclude();
    if (fails == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic hang();
    fails++;
    conclude();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OK);
    int k;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (k = 0; k < 99 && !(s_axi_bvalid && s_axi_bready); k++) begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    if (k == 99) hang();
    chk(32'(s_axi_bresp), 32'(er));
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er = RESP_OK);
    int k;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 99 && !(s_axi_rvalid && s_axi_rready); k++) begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    if (k == 99) hang();
    d = s_axi_rdata;
    chk(32'(s_axi_rresp), 32'(er));
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] r;
    rd(a, r);
    chk(r & m, e);
  endtask
  // Caught frame: n data bits, stop high above them
  function automatic logic [12:0] frame(input logic [8:0] d, input int n);
    return (13'h1fff << n) | (13'(d) & ~(13'h1fff << n));
  endfunction
  ////////////////////////////////////////
  initial begin
    logic [31:0] r;
    logic [12:0] v;
    logic [8:0] d;
    logic t9, hs;
    void'($urandom(52));
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    rc(A_TXCS, 32'hffffffff, 32'h2);
    rc(A_RXCS, 32'hffffffff, 32'h0);
    rd(8'h14, r, RESP_ERR);
    chk(r, 32'h0);
    chk(32'(tx_ck_oe), 32'h0);
    wr(A_BAUD, 32'h1);
    wr(A_RXCS, 32'h90);
    repeat (3) @(posedge sys_clk);
    chk({30'h0, tx_ck_oe, tx_ck_i}, 32'h3);
    // Every length and speed pair, full duplex, random data
    for (int i = 0; i < 4; i++) begin
      d = 9'($urandom);
      t9 = i[0];
      hs = i[1];
      wr(A_TXCS, {24'h0, 1'b0, t9, 1'b1, 2'b00, hs, 1'b0, d[8]});
      wr(A_RXCS, {24'h0, 1'b1, t9, 6'h10});
      fork
        peer.catch(8 + t9, hs ? 8 : 32, v);
        peer.send(~d, 8 + t9, hs ? 8 : 32, 1'b1);
        begin
          wr(A_TXD, {24'h0, d[7:0]});
          rc(A_TXCS, 32'h2, 32'h0);
        end
      join
      chk(32'(v), 32'(frame(d, 8 + t9)));
      rc(A_RXD, t9 ? 32'h1ff : 32'hff, 32'(~d & (t9 ? 9'h1ff : 9'h0ff)));
    end
    wr(A_TXCS, 32'h2c);
    fork
      peer.catch(12, 8, v);
      wr(A_TXD, 32'h55);
    join
    chk(32'(v), 32'h1000);
    // The break bit clears only at the end of the stop bit, after the last sample
    repeat (8) @(posedge sys_clk);
    rc(A_TXCS, 32'h8, 32'h0);
    wr(A_RXCS, 32'h90);
    peer.send(9'h5a, 8, 8, 1'b0);
    rc(A_RXCS, 32'h4, 32'h4);
    rc(A_RXD, 32'hff, 32'h5a);
    rc(A_RXCS, 32'h4, 32'h0);
    // Third word finds the buffer full
    for (int i = 0; i < 3; i++) peer.send(9'(i + 1), 8, 8, 1'b1);
    rc(A_RXCS, 32'h2, 32'h2);
    rc(A_RXD, 32'hff, 32'h1);
    rc(A_RXCS, 32'h2, 32'h2);
    wr(A_RXCS, 32'h80);
    rc(A_RXCS, 32'h2, 32'h0);
    wr(A_RXCS, 32'h0);
    // Pin enable follows the port bit one cycle later
    repeat (2) @(posedge sys_clk);
    chk(32'(tx_ck_oe), 32'h0);
    wr(A_TXCS, 32'h10);
    wr(A_RXCS, 32'h90);
    chk({30'h0, tx_ck_oe, rx_dt_oe}, 32'h0);
    d = 9'($urandom);
    peer.ssend(d[7:0]);
    repeat (4) @(posedge sys_clk);
    rc(A_RXD, 32'hff, 32'(d[7:0]));
    // Master single receive; the data line rests where the peer left it
    wr(A_RXCS, 32'h0);
    wr(A_TXCS, 32'h90);
    wr(A_RXCS, 32'ha0);
    repeat (60) @(posedge sys_clk);
    chk(32'(tx_ck_oe), 32'h1);
    rc(A_RXD, 32'hff, d[7] ? 32'h0 : 32'hff);
    rc(A_RXCS, 32'h20, 32'h0);
    conclude();
  end
endmodule
